/* File: verilog/sdi12_handler_pkg.sv */
// shared constants and types for the sdi-12 sensor command handler
package sdi12_handler_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SECOND_NS     = 1_000_000_000;
  localparam int TICKS_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  // ==========================================================
  // characters
  localparam logic [7:0] CH_BANG    = 8'h21;
  localparam logic [7:0] CH_QUERY   = 8'h3F;
  localparam logic [7:0] CH_CR      = 8'h0D;
  localparam logic [7:0] CH_LF      = 8'h0A;
  localparam logic [7:0] CH_PLUS    = 8'h2B;
  localparam logic [7:0] CH_MINUS   = 8'h2D;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_NINE    = 8'h39;
  localparam logic [7:0] CH_A       = 8'h41;
  localparam logic [7:0] CH_C       = 8'h43;
  localparam logic [7:0] CH_D       = 8'h44;
  localparam logic [7:0] CH_M       = 8'h4D;
  localparam logic [7:0] CH_R       = 8'h52;
  localparam logic [7:0] CH_V       = 8'h56;
  localparam logic [7:0] CRC_BASE   = 8'h40;
  localparam logic [7:0] ADDR_RESET = 8'h30;
  // ==========================================================
  // limits and check code
  localparam logic [6:0]  LIMIT_NORMAL = 7'h23;
  localparam logic [6:0]  LIMIT_CONC   = 7'h4B;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [15:0] CRC_INIT     = 16'h0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {RD_CHAR, RD_POS, RD_NEG, RD_END} rd_kind_t;
  typedef struct packed {
    rd_kind_t   kind;
    logic [7:0] ch;
  } rd_word_t;
  typedef struct packed {
    logic       verify;
    logic       conc;
    logic       crc;
    logic [3:0] idx;
  } meas_req_t;
  typedef struct packed {
    logic [11:0] ttt;
    logic [7:0]  n;
  } meas_info_t;
endpackage

/* File: verilog/sdi12_sensor_command_handler.sv */
// sdi-12 sensor command parser, measurement timer and reply sequencer
//
// Behaviour
// - verify command answers address, three-digit seconds and one-digit value count
// - address query answers own address whatever address is set
// - address change with matching address adopts new address and echoes it
// - normal measurement start answers address, seconds, count clamped to zero..nine; concurrent start answers two count digits
// - normal measurement sends address plus cr lf when data is ready
// - concurrent measurement sends no service request; recorder waits the time
// - send-data after normal measurement carries at most 35 data characters
// - send-data after concurrent measurement carries at most 75 data characters
// - each value opens with plus or minus sign, also the separator
// - crc-requested data replies end with three crc characters before cr lf
// - break during normal measurement abandons it
// - valid addressed command during concurrent measurement abandons it
// - every reply ends with carriage return then line feed
// - command is address, upper-case letter, qualifiers, exclamation mark
`timescale 1ns/1ps
`default_nettype none
module sdi12_sensor_command_handler
  import sdi12_handler_pkg::*;
#(
  parameter int TICKS_SEC = TICKS_PER_SEC
)(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  // received characters
  input  wire logic [7:0] rx_char_in,
  input  wire logic       rx_valid_in,
  input  wire logic       break_in,
  // reply characters
  output logic      [7:0] tx_char_out,
  output logic            tx_valid_out,
  input  wire logic       tx_ready_in,
  // measurement core
  output meas_req_t       meas_req_out,
  output logic            meas_start_out,
  output logic            meas_abort_out,
  input  wire meas_info_t meas_info_in,
  input  wire logic       meas_done_in,
  // value store read port
  output logic      [3:0] rd_set_out,
  output logic            rd_cont_out,
  output logic      [6:0] rd_pos_out,
  input  wire rd_word_t   rd_word_in,
  // status
  output logic      [7:0] address_out
);

  typedef enum logic [3:0] {S_IDLE, S_ADDR, S_TTT, S_N, S_REQ, S_GET, S_CRC, S_CR, S_LF} state_t;
  typedef enum logic [1:0] {K_ADDR, K_TIME, K_DATA} kind_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // registers
  logic [7:0]  cmd_reg [0:3];
  logic [2:0]  len_reg;
  logic        ovf_reg;
  logic [7:0]  addr_reg;
  state_t      state_reg, state_next;
  kind_t       kind_reg;
  logic [1:0]  step_reg, step_next;
  logic [6:0]  pos_reg, pos_next;
  logic [6:0]  cnt_reg, cnt_next;
  logic        sign_reg, sign_next;
  logic [15:0] crc_reg, crc_next;
  logic [7:0]  reply_reg;
  logic        two_reg;
  logic        crc_on_reg;
  logic [6:0]  limit_reg;
  logic [11:0] ttt_reg;
  logic [7:0]  n_reg;
  logic        meas_active_reg, meas_conc_reg;
  logic        data_conc_reg, data_crc_reg;
  logic        sr_pending_reg;
  logic [31:0] tick_reg;
  logic [9:0]  sec_reg;
  logic        start_reg, abort_reg;
  meas_req_t   req_reg;
  logic [3:0]  set_reg;
  logic        cont_reg;
  logic [7:0]  d0_reg, d1_reg, d0_next, d1_next;
  logic        v0_reg, v1_reg, v0_next, v1_next;

  // ==========================================================
  // command decode
  logic [7:0] c0, c1, c2, c3;
  logic       d2, d3, q_crc, addr_ok, mc;
  logic       is_query, is_ack, is_chg, is_ver, is_meas, is_dat, is_cont;
  logic       valid_cmd, fire, launch;
  logic [3:0] cmd_idx;
  assign c0       = cmd_reg[0];
  assign c1       = cmd_reg[1];
  assign c2       = cmd_reg[2];
  assign c3       = cmd_reg[3];
  assign d2       = (c2 >= CH_ZERO) && (c2 <= CH_NINE);
  assign d3       = (c3 >= CH_ZERO) && (c3 <= CH_NINE);
  assign q_crc    = c2 == CH_C;
  assign addr_ok  = c0 == addr_reg;
  assign mc       = (c1 == CH_M) || (c1 == CH_C);
  assign is_query = (len_reg == 3'h1) && (c0 == CH_QUERY);
  assign is_ack   = (len_reg == 3'h1) && addr_ok;
  assign is_chg   = (len_reg == 3'h3) && addr_ok && (c1 == CH_A);
  assign is_ver   = (len_reg == 3'h2) && addr_ok && (c1 == CH_V);
  assign is_meas  = addr_ok && mc && ((len_reg == 3'h2) || ((len_reg == 3'h3) && (q_crc || d2))
                    || ((len_reg == 3'h4) && q_crc && d3));
  assign is_dat   = addr_ok && (len_reg == 3'h3) && (c1 == CH_D) && d2;
  assign is_cont  = addr_ok && (c1 == CH_R) && (((len_reg == 3'h3) && d2) || ((len_reg == 3'h4) && q_crc && d3));
  assign valid_cmd = is_ack || is_chg || is_ver || is_meas || is_dat || is_cont;
  assign fire     = rx_valid_in && (rx_char_in == CH_BANG) && !ovf_reg && (state_reg == S_IDLE);
  assign cmd_idx  = (len_reg == 3'h4) ? c3[3:0] : ((len_reg == 3'h3) && d2) ? c2[3:0] : 4'h0;

  // ==========================================================
  // measurement timer
  logic [9:0] ttt_bin;
  logic       tick, expire, start, abort_n, abort_c, done_sr, sr_go;
  assign ttt_bin = {6'h00, meas_info_in.ttt[11:8]} * 10'h064 + {6'h00, meas_info_in.ttt[7:4]} * 10'h00A
                   + {6'h00, meas_info_in.ttt[3:0]};
  assign tick    = tick_reg == 32'(TICKS_SEC - 1);
  assign expire  = meas_active_reg && (sec_reg == 10'h000);
  assign start   = fire && (is_meas || is_ver);
  assign abort_n = meas_active_reg && !meas_conc_reg && break_in;
  assign abort_c = meas_active_reg && meas_conc_reg && fire && valid_cmd;
  assign done_sr = meas_active_reg && !meas_conc_reg && meas_done_in;
  assign sr_go   = (state_reg == S_IDLE) && !fire && sr_pending_reg;
  assign launch  = (fire && (is_query || valid_cmd)) || sr_go;

  // ==========================================================
  // reply sequencer
  logic       emit_ok, emit, is_sign;
  logic [7:0] ch, n_one;
  logic [3:0] ttt_nib;
  assign emit_ok = !v1_reg;
  assign is_sign = (rd_word_in.kind == RD_POS) || (rd_word_in.kind == RD_NEG);
  assign ttt_nib = (step_reg == 2'h0) ? ttt_reg[11:8] : (step_reg == 2'h1) ? ttt_reg[7:4] : ttt_reg[3:0];
  assign n_one   = (!two_reg && (n_reg[7:4] != 4'h0)) ? CH_NINE : (CH_ZERO | {4'h0, n_reg[3:0]});

  always_comb begin
    state_next = state_reg;
    step_next  = step_reg;
    pos_next   = pos_reg;
    cnt_next   = cnt_reg;
    sign_next  = sign_reg;
    crc_next   = crc_reg;
    emit       = 1'b0;
    ch         = CH_CR;
    unique case (state_reg)
      S_IDLE: begin
        if (launch) begin
          state_next = S_ADDR;
          step_next  = 2'h0;
          pos_next   = 7'h00;
          cnt_next   = 7'h00;
          sign_next  = 1'b0;
          crc_next   = CRC_INIT;
        end
      end
      S_ADDR: begin
        ch   = reply_reg;
        emit = emit_ok;
        if (emit) begin
          state_next = (kind_reg == K_ADDR) ? S_CR : (kind_reg == K_TIME) ? S_TTT : S_REQ;
        end
      end
      S_TTT: begin
        ch   = CH_ZERO | {4'h0, ttt_nib};
        emit = emit_ok;
        if (emit) begin
          step_next  = (step_reg == 2'h2) ? 2'h0 : step_reg + 2'h1;
          state_next = (step_reg == 2'h2) ? S_N : S_TTT;
        end
      end
      S_N: begin
        ch   = (two_reg && (step_reg == 2'h0)) ? (CH_ZERO | {4'h0, n_reg[7:4]}) : n_one;
        emit = emit_ok;
        if (emit) begin
          step_next  = (two_reg && (step_reg == 2'h0)) ? 2'h1 : 2'h0;
          state_next = (two_reg && (step_reg == 2'h0)) ? S_N : S_CR;
        end
      end
      S_REQ: state_next = S_GET;
      S_GET: begin
        if ((rd_word_in.kind == RD_END) || (cnt_reg >= limit_reg)) begin
          state_next = crc_on_reg ? S_CRC : S_CR;
        end else if (is_sign && !sign_reg) begin
          ch   = (rd_word_in.kind == RD_NEG) ? CH_MINUS : CH_PLUS;
          emit = emit_ok;
          if (emit) begin
            sign_next = 1'b1;
            cnt_next  = cnt_reg + 7'h01;
          end
        end else begin
          ch   = rd_word_in.ch;
          emit = emit_ok;
          if (emit) begin
            sign_next  = 1'b0;
            cnt_next   = cnt_reg + 7'h01;
            pos_next   = pos_reg + 7'h01;
            state_next = S_REQ;
          end
        end
      end
      S_CRC: begin
        ch   = CRC_BASE | ((step_reg == 2'h0) ? {4'h0, crc_reg[15:12]} :
               (step_reg == 2'h1) ? {2'h0, crc_reg[11:6]} : {2'h0, crc_reg[5:0]});
        emit = emit_ok;
        if (emit) begin
          step_next  = (step_reg == 2'h2) ? 2'h0 : step_reg + 2'h1;
          state_next = (step_reg == 2'h2) ? S_CR : S_CRC;
        end
      end
      S_CR: begin
        ch   = CH_CR;
        emit = emit_ok;
        if (emit) state_next = S_LF;
      end
      S_LF: begin
        ch   = CH_LF;
        emit = emit_ok;
        if (emit) state_next = S_IDLE;
      end
    endcase
    if (emit && (state_reg != S_CRC) && (state_reg != S_CR) && (state_reg != S_LF)) begin
      crc_next = crc_step(crc_reg, ch);
    end
  end

  // ==========================================================
  // two-entry output buffer
  always_comb begin
    d0_next = d0_reg;
    d1_next = d1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    if (v0_reg && tx_ready_in) begin
      if (v1_reg) begin
        d0_next = d1_reg;
        v1_next = 1'b0;
      end else begin
        v0_next = 1'b0;
      end
    end
    if (emit) begin
      if (!v0_next) begin
        d0_next = ch;
        v0_next = 1'b1;
      end else begin
        d1_next = ch;
        v1_next = 1'b1;
      end
    end
  end

  // ==========================================================
  // clocked state
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < 4; i++) cmd_reg[i] <= 8'h00;
      len_reg <= 3'h0;
      ovf_reg <= 1'b0;
    end else if (break_in || (rx_valid_in && (rx_char_in == CH_BANG))) begin
      len_reg <= 3'h0;
      ovf_reg <= 1'b0;
    end else if (rx_valid_in) begin
      if (len_reg < 3'h4) cmd_reg[len_reg[1:0]] <= rx_char_in;
      if (len_reg < 3'h4) len_reg <= len_reg + 3'h1;
      else ovf_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= S_IDLE;
      step_reg  <= 2'h0;
      pos_reg   <= 7'h00;
      cnt_reg   <= 7'h00;
      sign_reg  <= 1'b0;
      crc_reg   <= CRC_INIT;
      d0_reg    <= 8'h00;
      d1_reg    <= 8'h00;
      v0_reg    <= 1'b0;
      v1_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg  <= step_next;
      pos_reg   <= pos_next;
      cnt_reg   <= cnt_next;
      sign_reg  <= sign_next;
      crc_reg   <= crc_next;
      d0_reg    <= d0_next;
      d1_reg    <= d1_next;
      v0_reg    <= v0_next;
      v1_reg    <= v1_next;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      addr_reg   <= ADDR_RESET;
      reply_reg  <= ADDR_RESET;
      kind_reg   <= K_ADDR;
      two_reg    <= 1'b0;
      crc_on_reg <= 1'b0;
      limit_reg  <= LIMIT_NORMAL;
      ttt_reg    <= 12'h000;
      n_reg      <= 8'h00;
      set_reg    <= 4'h0;
      cont_reg   <= 1'b0;
    end else if (sr_go) begin
      reply_reg  <= addr_reg;
      kind_reg   <= K_ADDR;
      crc_on_reg <= 1'b0;
    end else if (fire) begin
      reply_reg  <= is_chg ? c2 : addr_reg;
      addr_reg   <= is_chg ? c2 : addr_reg;
      kind_reg   <= (is_ver || is_meas) ? K_TIME : (is_dat || is_cont) ? K_DATA : K_ADDR;
      two_reg    <= is_meas && (c1 == CH_C);
      ttt_reg    <= meas_info_in.ttt;
      n_reg      <= meas_info_in.n;
      crc_on_reg <= is_dat ? data_crc_reg : (is_cont && q_crc);
      limit_reg  <= (is_cont || data_conc_reg) ? LIMIT_CONC : LIMIT_NORMAL;
      set_reg    <= is_dat ? c2[3:0] : cmd_idx;
      cont_reg   <= is_cont;
    end
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meas_active_reg <= 1'b0;
      meas_conc_reg   <= 1'b0;
      data_conc_reg   <= 1'b0;
      data_crc_reg    <= 1'b0;
      sr_pending_reg  <= 1'b0;
      tick_reg        <= 32'h0000_0000;
      sec_reg         <= 10'h000;
      start_reg       <= 1'b0;
      abort_reg       <= 1'b0;
      req_reg         <= '0;
    end else begin
      start_reg      <= start;
      abort_reg      <= abort_n || abort_c;
      sr_pending_reg <= done_sr || (sr_pending_reg && !sr_go);
      tick_reg       <= (start || tick) ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      if (start) begin
        meas_active_reg <= 1'b1;
        meas_conc_reg   <= is_meas && (c1 == CH_C);
        data_conc_reg   <= is_meas && (c1 == CH_C);
        data_crc_reg    <= is_meas && q_crc;
        sec_reg         <= ttt_bin;
        req_reg         <= '{verify: is_ver, conc: is_meas && (c1 == CH_C), crc: is_meas && q_crc, idx: cmd_idx};
      end else begin
        if (abort_n || abort_c || expire || done_sr) meas_active_reg <= 1'b0;
        if (tick && (sec_reg != 10'h000)) sec_reg <= sec_reg - 10'h001;
      end
    end
  end

  // ==========================================================
  // outputs
  assign tx_char_out    = d0_reg;
  assign tx_valid_out   = v0_reg;
  assign meas_req_out   = req_reg;
  assign meas_start_out = start_reg;
  assign meas_abort_out = abort_reg;
  assign rd_set_out     = set_reg;
  assign rd_cont_out    = cont_reg;
  assign rd_pos_out     = pos_reg;
  assign address_out    = addr_reg;

endmodule
`default_nettype wire

/* File: bench/sdi12_handler_checker.sv */
// port assertions for the sdi-12 sensor command handler
`timescale 1ns/1ps
`default_nettype none
module sdi12_handler_checker
  import sdi12_handler_pkg::*;
#(
  parameter int TICKS_SEC = TICKS_PER_SEC
)(
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  input wire logic [7:0] rx_char_in,
  input wire logic       rx_valid_in,
  input wire logic       break_in,
  input wire logic [7:0] tx_char_out,
  input wire logic       tx_valid_out,
  input wire logic       tx_ready_in,
  input wire meas_req_t  meas_req_out,
  input wire logic       meas_start_out,
  input wire logic       meas_abort_out
);
  // ==========================================================
  // reply tracking
  logic       last_cr_reg;
  logic [6:0] len_reg;
  wire        tx_taken = tx_valid_out && tx_ready_in;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      last_cr_reg <= 1'b0;
      len_reg     <= 7'h00;
    end else if (tx_taken) begin
      last_cr_reg <= (tx_char_out == CH_CR);
      len_reg     <= (tx_char_out == CH_LF) ? 7'h00 : len_reg + 7'h01;
    end
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_start_pulse: assert property (meas_start_out |=> !meas_start_out) else $error("start pulse too long");
  a_start_cause: assert property (meas_start_out |-> $past(rx_valid_in && rx_char_in == CH_BANG))
    else $error("start without command end");
  a_start_reply: assert property (meas_start_out |-> ##[0:3] tx_valid_out) else $error("no prompt answer");
  a_req_stable: assert property (!$stable(meas_req_out) |-> meas_start_out) else $error("request moved");
  a_abort_pulse: assert property (meas_abort_out |=> !meas_abort_out) else $error("abort pulse too long");
  a_abort_cause: assert property (meas_abort_out |-> $past(break_in || (rx_valid_in && rx_char_in == CH_BANG)))
    else $error("abort without cause");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out))
    else $error("reply char lost");
  a_lf_after_cr: assert property (tx_taken && last_cr_reg |-> tx_char_out == CH_LF) else $error("cr not followed by lf");
  a_reply_len: assert property (tx_taken |-> len_reg < 7'h51) else $error("reply too long");
endmodule
bind sdi12_sensor_command_handler sdi12_handler_checker #(.TICKS_SEC(TICKS_SEC)) u_checker (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .rx_char_in(rx_char_in), .rx_valid_in(rx_valid_in),
  .break_in(break_in), .tx_char_out(tx_char_out), .tx_valid_out(tx_valid_out), .tx_ready_in(tx_ready_in),
  .meas_req_out(meas_req_out), .meas_start_out(meas_start_out), .meas_abort_out(meas_abort_out));
`default_nettype wire

/* File: bench/sdi12_core_model.sv */
// measurement core and value store model facing the handler
`timescale 1ns/1ps
`default_nettype none
module sdi12_core_model
  import sdi12_handler_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  // store selection
  input  wire logic       long_in,
  // measurement
  input  wire logic       meas_start_in,
  output meas_info_t      meas_info_out,
  output logic            meas_done_out,
  // value store
  input  wire logic [6:0] rd_pos_in,
  output rd_word_t        rd_word_out
);
  logic [4:0] wait_reg;
  // two seconds, two values
  assign meas_info_out = '{ttt: 12'h002, n: 8'h02};
  // done follows every start, concurrent ones too
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_reg      <= 5'h00;
      meas_done_out <= 1'b0;
    end else begin
      meas_done_out <= (wait_reg == 5'h01);
      if (meas_start_in) begin
        wait_reg <= 5'h18;
      end else if (wait_reg != 5'h00) begin
        wait_reg <= wait_reg - 5'h01;
      end
    end
  end
  // one cycle read latency; long store never ends
  always_ff @(posedge clk_sys_in) begin
    if (long_in) begin
      rd_word_out <= '{kind: (rd_pos_in == 7'h00) ? RD_POS : RD_CHAR, ch: 8'h37};
    end else begin
      case (rd_pos_in)
        7'h00: rd_word_out <= '{kind: RD_POS, ch: 8'h31};
        7'h01: rd_word_out <= '{kind: RD_CHAR, ch: 8'h32};
        7'h02: rd_word_out <= '{kind: RD_NEG, ch: 8'h33};
        default: rd_word_out <= '{kind: RD_END, ch: 8'h00};
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the sdi-12 sensor command handler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sdi12_handler_pkg::*;
  // ==========================================================
  // signals
  logic       clk_sys_in;
  logic       sys_rst_in;
  logic [7:0] rx_char;
  logic       rx_valid;
  logic       brk;
  logic       tx_ready;
  logic       hold;
  logic       long_mode;
  logic [7:0] tx_char;
  logic       tx_valid;
  meas_req_t  req;
  logic       start;
  logic       abort;
  meas_info_t info;
  logic       done;
  logic [6:0] rd_pos;
  rd_word_t   rd_word;
  logic [3:0] rd_set;
  logic       rd_cont;
  logic [7:0] address;
  logic [7:0] rxq[$];
  int         num_errors;
  int         checked;
  int         aborts;
  int         cyc;
  // ==========================================================
  // design and partner
  sdi12_sensor_command_handler #(.TICKS_SEC(20)) u_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .rx_char_in(rx_char), .rx_valid_in(rx_valid),
    .break_in(brk), .tx_char_out(tx_char), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .meas_req_out(req), .meas_start_out(start), .meas_abort_out(abort), .meas_info_in(info),
    .meas_done_in(done), .rd_set_out(rd_set), .rd_cont_out(rd_cont), .rd_pos_out(rd_pos), .rd_word_in(rd_word),
    .address_out(address));
  sdi12_core_model u_core (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .long_in(long_mode), .meas_start_in(start),
    .meas_info_out(info), .meas_done_out(done), .rd_pos_in(rd_pos), .rd_word_out(rd_word));
  // ==========================================================
  // clock, receiver with stalls, timeout
  always #2 clk_sys_in = ~clk_sys_in;
  always @(negedge clk_sys_in) begin
    cyc++;
    if (abort === 1'b1) aborts++;
    tx_ready = !hold && (cyc[1:0] != 2'b11);
    if (tx_ready && tx_valid === 1'b1) rxq.push_back(tx_char);
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // ==========================================================
  // helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic string eol(input string s);
    return {s, "\015\012"};
  endfunction
  function automatic string crc3(input string s);
    logic [15:0] c;
    string       r;
    c = CRC_INIT;
    r = "@@@";
    for (int i = 0; i < s.len(); i++) begin
      c = c ^ {8'h00, s[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    r[0] = {4'h4, c[15:12]};
    r[1] = {2'b01, c[11:6]};
    r[2] = {2'b01, c[5:0]};
    return r;
  endfunction
  function automatic string long_rep(input int n, input bit crc);
    string s;
    s = "0+";
    repeat (n - 1) s = {s, "7"};
    if (crc) s = {s, crc3(s)};
    return eol(s);
  endfunction
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk_sys_in);
      rx_char = s[i];
      rx_valid = 1'b1;
      @(negedge clk_sys_in);
      rx_valid = 1'b0;
    end
  endtask
  task automatic expect_reply(input string s, input int limit);
    int n;
    n = 0;
    while ((rxq.size() == 0 || rxq[$] != CH_LF) && n < limit) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(rxq.size(), s.len());
    for (int i = 0; i < s.len() && i < rxq.size(); i++) check(rxq[i], s[i]);
    rxq.delete();
  endtask
  task automatic expect_silence(input int cycles);
    repeat (cycles) @(negedge clk_sys_in);
    check(rxq.size(), 0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_address;
    send("0!");
    expect_reply(eol("0"), 200);
    send("1M!");
    expect_silence(40);
    send("?!");
    expect_reply(eol("0"), 200);
    send("0A2!");
    expect_reply(eol("2"), 200);
    check(address, 8'h32);
    send("?!");
    expect_reply(eol("2"), 200);
    send("2A0!");
    expect_reply(eol("0"), 200);
    $display("address test done");
  endtask
  task automatic t_normal;
    send("0V!");
    expect_reply(eol("00022"), 200);
    check(req, 7'h40);
    expect_reply(eol("0"), 40);
    send("0MC!");
    expect_reply(eol("00022"), 200);
    check(req, 7'h10);
    expect_reply(eol("0"), 40);
    send("0D0!");
    expect_reply(eol({"0+12-3", crc3("0+12-3")}), 300);
    send("0D1!");
    expect_reply(eol({"0+12-3", crc3("0+12-3")}), 300);
    check(rd_set, 4'h1);
    check(rd_cont, 1'b0);
    send("0RC3!");
    expect_reply(eol({"0+12-3", crc3("0+12-3")}), 300);
    check(rd_set, 4'h3);
    check(rd_cont, 1'b1);
    $display("normal test done");
  endtask
  task automatic t_long;
    send("0CC!");
    expect_reply(eol("000202"), 200);
    check(req, 7'h30);
    expect_silence(60);
    long_mode = 1'b1;
    send("0D0!");
    hold = 1'b1;
    repeat (40) @(negedge clk_sys_in);
    hold = 1'b0;
    expect_reply(long_rep(75, 1'b1), 800);
    send("0M!");
    expect_reply(eol("00022"), 200);
    expect_reply(eol("0"), 40);
    send("0D0!");
    expect_reply(long_rep(35, 1'b0), 800);
    long_mode = 1'b0;
    $display("limit test done");
  endtask
  task automatic t_abort;
    int a0;
    a0 = aborts;
    send("0M!");
    expect_reply(eol("00022"), 200);
    brk = 1'b1;
    @(negedge clk_sys_in);
    brk = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    check(aborts, a0 + 1);
    expect_silence(60);
    send("0C1!");
    expect_reply(eol("000202"), 200);
    check(req, 7'h21);
    send("0!");
    expect_reply(eol("0"), 200);
    check(aborts, a0 + 2);
    $display("abort test done");
  endtask
  // ==========================================================
  // verdict
  task automatic complete_run;
    $display("compared %0d, mismatched %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    sys_rst_in = 1'b1;
    rx_char = 8'h00;
    rx_valid = 1'b0;
    brk = 1'b0;
    hold = 1'b0;
    long_mode = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    t_address();
    t_normal();
    t_long();
    t_abort();
    complete_run();
  end
endmodule
`default_nettype wire
